// *** include/rtsc_consts.vh ***
// Constants for the reading timestamp clock
`ifndef RTSC_CONSTS_VH
`define RTSC_CONSTS_VH
`define RTSC_CLK_NS       5
`define RTSC_US_NS        1000
`define RTSC_SEC_NS       1000000000
`define RTSC_US_CYC       (`RTSC_US_NS / `RTSC_CLK_NS)
`define RTSC_SEC_CYC      (`RTSC_SEC_NS / `RTSC_CLK_NS)
`define RTSC_REL_SEC_MAX  17'd99999
`define RTSC_REL_US_MAX   20'd999999
`define RTSC_OFS_CTRL     8'h00
`define RTSC_OFS_CMD      8'h04
`define RTSC_OFS_TIME     8'h08
`define RTSC_OFS_DATE     8'h0c
`define RTSC_OFS_ALARM    8'h10
`define RTSC_OFS_REL_SEC  8'h14
`define RTSC_OFS_REL_US   8'h18
`define RTSC_OFS_RDG_NUM  8'h1c
`define RTSC_CTRL_TYPE    0
`define RTSC_CTRL_FMT12   1
`define RTSC_CTRL_EL_TS   2
`define RTSC_CTRL_EL_RDG  3
`define RTSC_CMD_REL_CLR  0
`define RTSC_CMD_RDG_CLR  1
`define RTSC_CMD_SEC_ZERO 2
`define RTSC_ALARM_EN     31
`define RTSC_RESP_OKAY    2'b00
`define RTSC_RESP_SLVERR  2'b10
`define RTSC_RST_HOUR     5'h00
`define RTSC_RST_DAY      5'h01
`define RTSC_RST_MONTH    4'h1
`define RTSC_RST_YEAR     7'h00
`endif

// *** logic/rtsc_calendar.v ***
// Calendar clock with time, date and weekday
`timescale 1ns/1ps
`include "rtsc_consts.vh"
module rtsc_calendar #(
	parameter SEC_CYC = `RTSC_SEC_CYC
) (
	input  wire       i_sys_clk,
	input  wire       i_sys_rst,
	input  wire       i_set_time,
	input  wire       i_set_date,
	input  wire       i_sec_zero,
	input  wire [4:0] i_hour,
	input  wire [5:0] i_min,
	input  wire [5:0] i_sec,
	input  wire [4:0] i_day,
	input  wire [3:0] i_month,
	input  wire [6:0] i_year,
	output reg  [4:0] o_hour,
	output reg  [5:0] o_min,
	output reg  [5:0] o_sec,
	output reg  [4:0] o_day,
	output reg  [3:0] o_month,
	output reg  [6:0] o_year,
	output reg  [2:0] o_dow
);
	reg  [31:0] pre;
	wire        tick = (pre == SEC_CYC - 1);
	wire [4:0]  mdays = days_in(o_month, o_year);

	// Years 2000..2099, every fourth one leap
	function [4:0] days_in(input [3:0] m, input [6:0] y);
		begin
			case (m)
				4'h2:    days_in = (y[1:0] == 2'b00) ? 5'd29 : 5'd28;
				4'h4, 4'h6, 4'h9, 4'hb: days_in = 5'd30;
				default: days_in = 5'd31;
			endcase
		end
	endfunction

	// Weekday, 0 is Sunday
	function [2:0] weekday(input [4:0] d, input [3:0] m, input [6:0] y);
		reg [11:0] yy;
		reg [3:0]  t;
		reg [13:0] s;
		reg [13:0] rem;
		begin
			yy = 12'd2000 + {5'h00, y} - ((m < 4'h3) ? 12'd1 : 12'd0);
			case (m)
				4'h1: t = 4'd0; 4'h2: t = 4'd3; 4'h3: t = 4'd2; 4'h4: t = 4'd5;
				4'h5: t = 4'd0; 4'h6: t = 4'd3; 4'h7: t = 4'd5; 4'h8: t = 4'd1;
				4'h9: t = 4'd4; 4'ha: t = 4'd6; 4'hb: t = 4'd2; default: t = 4'd4;
			endcase
			s = {2'b00, yy} + {4'h0, yy[11:2]} - {2'b00, yy / 12'd100}
				+ {2'b00, yy / 12'd400} + {10'h000, t} + {9'h000, d};
			rem     = s % 14'd7;
			weekday = rem[2:0];
		end
	endfunction

	always @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			pre     <= 32'h00000000;
			o_hour  <= `RTSC_RST_HOUR;
			o_min   <= 6'h00;
			o_sec   <= 6'h00;
			o_day   <= `RTSC_RST_DAY;
			o_month <= `RTSC_RST_MONTH;
			o_year  <= `RTSC_RST_YEAR;
			o_dow   <= 3'h0;
		end else begin
			o_dow <= weekday(o_day, o_month, o_year); // [RULE11]
			pre   <= (tick || i_set_time || i_sec_zero) ? 32'h00000000 : pre + 32'h00000001;
			if (i_set_time) begin
				o_hour <= i_hour; // [RULE12]
				o_min  <= i_min;
				o_sec  <= i_sec;
			end else if (i_sec_zero) begin
				o_sec <= 6'h00; // [RULE12]
			end else if (tick) begin
				if (o_sec != 6'd59)
					o_sec <= o_sec + 6'h01;
				else begin
					o_sec <= 6'h00;
					if (o_min != 6'd59)
						o_min <= o_min + 6'h01;
					else begin
						o_min  <= 6'h00;
						o_hour <= (o_hour == 5'd23) ? 5'h00 : o_hour + 5'h01;
					end
				end
			end
			if (i_set_date) begin
				o_day   <= i_day;
				o_month <= i_month;
				o_year  <= i_year;
			end else if (tick && o_sec == 6'd59 && o_min == 6'd59 && o_hour == 5'd23 && !i_set_time
					&& !i_sec_zero) begin
				if (o_day != mdays)
					o_day <= o_day + 5'h01;
				else begin
					o_day <= 5'h01;
					if (o_month != 4'hc)
						o_month <= o_month + 4'h1;
					else begin
						o_month <= 4'h1;
						o_year  <= (o_year == 7'd99) ? 7'h00 : o_year + 7'h01;
					end
				end
			end
		end
	end
endmodule

// *** logic/rtsc_reltimer.v ***
// Relative timer in seconds and microseconds
`timescale 1ns/1ps
`include "rtsc_consts.vh"
module rtsc_reltimer #(
	parameter US_CYC = `RTSC_US_CYC
) (
	input  wire        i_sys_clk,
	input  wire        i_sys_rst,
	input  wire        i_clear,
	output reg  [16:0] o_sec,
	output reg  [19:0] o_us
);
	reg [15:0] pre;

	always @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			pre   <= 16'h0000; // [RULE1]
			o_us  <= 20'h00000;
			o_sec <= 17'h00000;
		end else if (i_clear) begin
			// Prescaler restarts too, so the first microsecond is whole
			pre   <= 16'h0000; // [RULE1] [RULE5]
			o_us  <= 20'h00000;
			o_sec <= 17'h00000;
		end else if (pre == US_CYC[15:0] - 16'h0001) begin
			pre <= 16'h0000; // [RULE14]
			if (o_us == `RTSC_REL_US_MAX) begin
				o_us <= 20'h00000;
				if (o_sec == `RTSC_REL_SEC_MAX)
					o_sec <= 17'h00000; // [RULE2]
				else
					o_sec <= o_sec + 17'h00001;
			end else begin
				o_us <= o_us + 20'h00001;
			end
		end else begin
			pre <= pre + 16'h0001;
		end
	end
endmodule

// *** logic/rtsc_top.v ***
// Reading timestamp clock with register slave
// Overview of operation
// RULE1: relative timer starts at zero, reset, command
// RULE2: relative timer wraps to zero past maximum
// RULE3: changing timestamp type clears reading buffer
// RULE4: one timestamp type for bus and buffer
// RULE5: relative reset leaves calendar clock alone
// RULE6: reading number zeroed at reset and command
// RULE7: bus tags only when their elements enabled
// RULE8: real-time tags carry clock time and date
// RULE9: bus real-time tags always 24-hour
// RULE10: buffer tags follow hour format, AM/PM
// RULE11: weekday derived from the calendar date
// RULE12: time as h/m/s; seconds-zero command
// RULE13: clock alarm arms layer one, selected format
// RULE14: relative timer counts microseconds via prescaler
`timescale 1ns/1ps
`include "rtsc_consts.vh"
module rtsc_top #(
	parameter US_CYC  = `RTSC_US_CYC,
	parameter SEC_CYC = `RTSC_SEC_CYC
) (
	input  wire        i_sys_clk,
	input  wire        i_sys_rst,
	input  wire [7:0]  i_s_axi_awaddr,
	input  wire        i_s_axi_awvalid,
	output reg         o_s_axi_awready,
	input  wire [31:0] i_s_axi_wdata,
	input  wire [3:0]  i_s_axi_wstrb,
	input  wire        i_s_axi_wvalid,
	output reg         o_s_axi_wready,
	output reg  [1:0]  o_s_axi_bresp,
	output reg         o_s_axi_bvalid,
	input  wire        i_s_axi_bready,
	input  wire [7:0]  i_s_axi_araddr,
	input  wire        i_s_axi_arvalid,
	output reg         o_s_axi_arready,
	output reg  [31:0] o_s_axi_rdata,
	output reg  [1:0]  o_s_axi_rresp,
	output reg         o_s_axi_rvalid,
	input  wire        i_s_axi_rready,
	input  wire        i_reading_strobe,
	output reg         o_tag_valid,
	output reg         o_tag_real,
	output reg         o_bus_ts_en,
	output reg         o_bus_rdg_en,
	output reg  [16:0] o_rel_sec,
	output reg  [19:0] o_rel_us,
	output reg  [31:0] o_bus_time,
	output reg  [31:0] o_buf_time,
	output reg  [31:0] o_tag_date,
	output reg  [31:0] o_rdg_num,
	output reg         o_buffer_clear,
	output reg         o_arm_event
);
	reg  [3:0]  ctrl;
	reg  [31:0] alarm;
	reg  [7:0]  aw_addr;
	reg  [31:0] w_data;
	reg  [3:0]  w_strb;
	reg         aw_got;
	reg         w_got;
	reg         rel_clr;
	reg         sec_zero;
	reg         set_time;
	reg         set_date;
	reg         rdg_clr;
	reg  [4:0]  ld_hour;
	reg  [5:0]  ld_min;
	reg  [5:0]  ld_sec;
	reg  [4:0]  ld_day;
	reg  [3:0]  ld_month;
	reg  [6:0]  ld_year;
	reg         alarm_hit;
	reg  [31:0] rd_word;
	reg         rd_ok;
	reg  [31:0] next_ctrl_word;
	wire [16:0] rt_sec;
	wire [19:0] rt_us;
	wire [4:0]  c_hour;
	wire [5:0]  c_min;
	wire [5:0]  c_sec;
	wire [4:0]  c_day;
	wire [3:0]  c_month;
	wire [6:0]  c_year;
	wire [2:0]  c_dow;
	wire        do_write = aw_got && w_got && !o_s_axi_bvalid;
	wire        fmt12 = ctrl[`RTSC_CTRL_FMT12];
	wire [31:0] time24 = pack_time(c_hour, 1'b0, c_min, c_sec);
	wire [4:0]  h12 = (c_hour == 5'd0) ? 5'd12 : (c_hour > 5'd12) ? c_hour - 5'd12 : c_hour;
	wire [31:0] time12 = pack_time(h12, c_hour >= 5'd12, c_min, c_sec);
	wire [31:0] date_word = {5'h00, c_dow, 1'b0, c_year, 4'h0, c_month, 3'h0, c_day};
	wire [4:0]  al_hour = to_24(alarm[20:16], alarm[24], alarm[`RTSC_ALARM_EN] & fmt12);
	wire        alarm_now = alarm[`RTSC_ALARM_EN] && al_hour == c_hour
		&& alarm[13:8] == c_min && alarm[5:0] == c_sec;

	// Time word: seconds [5:0], minutes [13:8], hour [20:16], PM flag [24]
	function [31:0] pack_time(input [4:0] h, input pm, input [5:0] m, input [5:0] s);
		begin
			pack_time = {7'h00, pm, 3'h0, h, 2'h0, m, 2'h0, s};
		end
	endfunction

	// Hour as entered in the selected format, turned to 0..23
	function [4:0] to_24(input [4:0] h, input pm, input is12);
		begin
			if (!is12)
				to_24 = h;
			else if (h == 5'd12)
				to_24 = pm ? 5'd12 : 5'd0;
			else
				to_24 = pm ? h + 5'd12 : h;
		end
	endfunction

	// Byte-lane merge for the control and alarm registers
	function [31:0] merge(input [31:0] old, input [31:0] nw, input [3:0] st);
		integer k;
		begin
			merge = old;
			for (k = 0; k < 4; k = k + 1)
				if (st[k])
					merge[k*8 +: 8] = nw[k*8 +: 8];
		end
	endfunction

	rtsc_reltimer #(
		.US_CYC (US_CYC)
	) u_rel (
		.i_sys_clk (i_sys_clk),
		.i_sys_rst (i_sys_rst),
		.i_clear   (rel_clr),
		.o_sec     (rt_sec),
		.o_us      (rt_us)
	);

	rtsc_calendar #(
		.SEC_CYC (SEC_CYC)
	) u_cal (
		.i_sys_clk  (i_sys_clk),
		.i_sys_rst  (i_sys_rst),
		.i_set_time (set_time),
		.i_set_date (set_date),
		.i_sec_zero (sec_zero),
		.i_hour     (ld_hour),
		.i_min      (ld_min),
		.i_sec      (ld_sec),
		.i_day      (ld_day),
		.i_month    (ld_month),
		.i_year     (ld_year),
		.o_hour     (c_hour),
		.o_min      (c_min),
		.o_sec      (c_sec),
		.o_day      (c_day),
		.o_month    (c_month),
		.o_year     (c_year),
		.o_dow      (c_dow)
	);

	always @* begin
		next_ctrl_word = merge({28'h0000000, ctrl}, w_data, w_strb);
		rd_ok   = 1'b1;
		rd_word = 32'h00000000;
		case (i_s_axi_araddr)
			`RTSC_OFS_CTRL:    rd_word = {28'h0000000, ctrl};
			`RTSC_OFS_CMD:     rd_word = 32'h00000000;
			`RTSC_OFS_TIME:    rd_word = time24;
			`RTSC_OFS_DATE:    rd_word = date_word;
			`RTSC_OFS_ALARM:   rd_word = alarm;
			`RTSC_OFS_REL_SEC: rd_word = {15'h0000, rt_sec};
			`RTSC_OFS_REL_US:  rd_word = {12'h000, rt_us};
			`RTSC_OFS_RDG_NUM: rd_word = o_rdg_num;
			default:           rd_ok = 1'b0;
		endcase
	end

	// Write channel: address and data taken in either order
	always @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_s_axi_awready <= 1'b1;
			o_s_axi_wready  <= 1'b1;
			o_s_axi_bvalid  <= 1'b0;
			o_s_axi_bresp   <= `RTSC_RESP_OKAY;
			aw_got   <= 1'b0;
			w_got    <= 1'b0;
			aw_addr  <= 8'h00;
			w_data   <= 32'h00000000;
			w_strb   <= 4'h0;
			ctrl     <= 4'h0;
			alarm    <= 32'h00000000;
			rel_clr  <= 1'b0;
			rdg_clr  <= 1'b0;
			sec_zero <= 1'b0;
			set_time <= 1'b0;
			set_date <= 1'b0;
			ld_hour  <= 5'h00;
			ld_min   <= 6'h00;
			ld_sec   <= 6'h00;
			ld_day   <= 5'h01;
			ld_month <= 4'h1;
			ld_year  <= 7'h00;
			o_buffer_clear <= 1'b0;
		end else begin
			rel_clr  <= 1'b0;
			rdg_clr  <= 1'b0;
			sec_zero <= 1'b0;
			set_time <= 1'b0;
			set_date <= 1'b0;
			o_buffer_clear <= 1'b0;
			if (i_s_axi_awvalid && o_s_axi_awready) begin
				aw_addr <= i_s_axi_awaddr;
				aw_got  <= 1'b1;
				o_s_axi_awready <= 1'b0;
			end
			if (i_s_axi_wvalid && o_s_axi_wready) begin
				w_data <= i_s_axi_wdata;
				w_strb <= i_s_axi_wstrb;
				w_got  <= 1'b1;
				o_s_axi_wready <= 1'b0;
			end
			if (o_s_axi_bvalid && i_s_axi_bready) begin
				o_s_axi_bvalid  <= 1'b0;
				o_s_axi_awready <= 1'b1;
				o_s_axi_wready  <= 1'b1;
			end
			if (do_write) begin
				aw_got <= 1'b0;
				w_got  <= 1'b0;
				o_s_axi_bvalid <= 1'b1;
				o_s_axi_bresp  <= `RTSC_RESP_OKAY;
				case (aw_addr)
					`RTSC_OFS_CTRL: begin
						ctrl <= next_ctrl_word[3:0]; // [RULE4]
						// Only a real change of type drops stored readings
						if (next_ctrl_word[`RTSC_CTRL_TYPE] != ctrl[`RTSC_CTRL_TYPE])
							o_buffer_clear <= 1'b1; // [RULE3]
					end
					`RTSC_OFS_CMD: if (w_strb[0]) begin
						rel_clr  <= w_data[`RTSC_CMD_REL_CLR]; // [RULE5]
						rdg_clr  <= w_data[`RTSC_CMD_RDG_CLR]; // [RULE6]
						sec_zero <= w_data[`RTSC_CMD_SEC_ZERO]; // [RULE12]
					end
					`RTSC_OFS_TIME: begin
						// Hour is entered in the format selected now
						ld_hour  <= to_24(w_data[20:16], w_data[24], fmt12); // [RULE12]
						ld_min   <= w_data[13:8];
						ld_sec   <= w_data[5:0];
						set_time <= 1'b1;
					end
					`RTSC_OFS_DATE: begin
						ld_day   <= w_data[4:0];
						ld_month <= w_data[11:8];
						ld_year  <= w_data[22:16];
						set_date <= 1'b1; // [RULE11]
					end
					`RTSC_OFS_ALARM: alarm <= merge(alarm, w_data, w_strb); // [RULE13]
					`RTSC_OFS_REL_SEC, `RTSC_OFS_REL_US, `RTSC_OFS_RDG_NUM: ;
					default: o_s_axi_bresp <= `RTSC_RESP_SLVERR;
				endcase
			end
		end
	end

	// Read channel: answer one cycle after the address is taken
	always @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_s_axi_arready <= 1'b1;
			o_s_axi_rvalid  <= 1'b0;
			o_s_axi_rdata   <= 32'h00000000;
			o_s_axi_rresp   <= `RTSC_RESP_OKAY;
		end else if (i_s_axi_arvalid && o_s_axi_arready) begin
			o_s_axi_arready <= 1'b0;
			o_s_axi_rvalid  <= 1'b1;
			o_s_axi_rdata   <= rd_word;
			o_s_axi_rresp   <= rd_ok ? `RTSC_RESP_OKAY : `RTSC_RESP_SLVERR;
		end else if (o_s_axi_rvalid && i_s_axi_rready) begin
			o_s_axi_rvalid  <= 1'b0;
			o_s_axi_arready <= 1'b1;
		end
	end

	// Reading tags and reading number
	always @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_rdg_num    <= 32'h00000000; // [RULE6]
			o_tag_valid  <= 1'b0;
			o_tag_real   <= 1'b0;
			o_bus_ts_en  <= 1'b0;
			o_bus_rdg_en <= 1'b0;
			o_rel_sec    <= 17'h00000;
			o_rel_us     <= 20'h00000;
			o_bus_time   <= 32'h00000000;
			o_buf_time   <= 32'h00000000;
			o_tag_date   <= 32'h00000000;
			o_arm_event  <= 1'b0;
			alarm_hit    <= 1'b0;
		end else begin
			o_tag_valid <= i_reading_strobe;
			// A reading in the clear cycle takes number one, not lost
			if (i_reading_strobe)
				o_rdg_num <= rdg_clr ? 32'h00000001 : o_rdg_num + 32'h00000001;
			else if (rdg_clr)
				o_rdg_num <= 32'h00000000; // [RULE6]
			if (i_reading_strobe) begin
				o_tag_real   <= ctrl[`RTSC_CTRL_TYPE]; // [RULE4]
				o_bus_ts_en  <= ctrl[`RTSC_CTRL_EL_TS]; // [RULE7]
				o_bus_rdg_en <= ctrl[`RTSC_CTRL_EL_RDG]; // [RULE7]
				o_rel_sec    <= rt_sec;
				o_rel_us     <= rt_us;
				o_bus_time   <= time24; // [RULE8] [RULE9]
				o_buf_time   <= fmt12 ? time12 : time24; // [RULE10]
				o_tag_date   <= date_word; // [RULE8]
			end
			// Edge of the match, so one pulse per alarm second
			alarm_hit   <= alarm_now;
			o_arm_event <= alarm_now && !alarm_hit; // [RULE13]
		end
	end
endmodule

// *** testbench/rtsc_assertions.sv ***
// Port-level property checker for the reading timestamp clock
`timescale 1ns/1ps
module rtsc_assertions #(
	parameter US_CYC  = 200,
	parameter SEC_CYC = 200000000
) (
	input logic        i_sys_clk,
	input logic        i_sys_rst,
	input logic        o_s_axi_awready,
	input logic        o_s_axi_wready,
	input logic        o_s_axi_bvalid,
	input logic        o_s_axi_arready,
	input logic        o_s_axi_rvalid,
	input logic        i_reading_strobe,
	input logic        o_tag_valid,
	input logic [16:0] o_rel_sec,
	input logic [19:0] o_rel_us,
	input logic [31:0] o_bus_time,
	input logic [31:0] o_buf_time,
	input logic [31:0] o_tag_date,
	input logic        o_buffer_clear,
	input logic        o_arm_event
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);
	// Expected 12-hour form of the bus hour
	wire [4:0] bh  = o_bus_time[20:16];
	wire [4:0] h12 = (bh == 5'h00 || bh == 5'h0c) ? 5'h0c : (bh > 5'h0c ? bh - 5'h0c : bh);
	chk_tag_after: assert property (i_reading_strobe |=> o_tag_valid)
		else $error("tag missing after strobe");
	chk_tag_cause: assert property (o_tag_valid |-> $past(i_reading_strobe))
		else $error("tag without strobe");
	chk_bus_24h: assert property (o_tag_valid |-> !o_bus_time[24] && bh < 5'h18)
		else $error("bus time not in 24-hour form");
	chk_buf_fmt: assert property (o_tag_valid |-> o_buf_time == o_bus_time ||
		(o_buf_time[20:16] == h12 && o_buf_time[24] == (bh >= 5'h0c) && o_buf_time[13:0] == o_bus_time[13:0]))
		else $error("buffer time in neither hour format");
	chk_rel_range: assert property (o_tag_valid |-> o_rel_us <= 20'hf423f && o_rel_sec <= 17'h1869f)
		else $error("relative time out of range");
	chk_date_ok: assert property (o_tag_valid |-> o_tag_date[26:24] < 3'h7 && o_tag_date[4:0] != 5'h00)
		else $error("bad weekday or day");
	chk_clr_cause: assert property (o_buffer_clear |-> $rose(o_s_axi_bvalid) ##1 !o_buffer_clear)
		else $error("buffer clear without write or too long");
	chk_w_blocked: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
		else $error("write accepted while response pending");
	chk_r_blocked: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
		else $error("read accepted while data pending");
	chk_arm_pulse: assert property (o_arm_event |=> !o_arm_event)
		else $error("arm event longer than one cycle");
endmodule
bind rtsc_top rtsc_assertions #(.US_CYC(US_CYC), .SEC_CYC(SEC_CYC)) u_chk (.*);

// *** testbench/tb_top.sv ***
// Self-checking bench for the reading timestamp clock
`timescale 1ns/1ps
`include "rtsc_consts.vh"
module tb_top;
	// Short counts keep the run brief
	localparam US_CYC  = 4;
	localparam SEC_CYC = 1000;
	logic        i_sys_clk = 0, i_sys_rst = 1, i_reading_strobe = 0;
	logic [7:0]  i_s_axi_awaddr = 0, i_s_axi_araddr = 0;
	logic [31:0] i_s_axi_wdata = 0;
	logic [3:0]  i_s_axi_wstrb = 0;
	logic        i_s_axi_awvalid = 0, i_s_axi_wvalid = 0, i_s_axi_bready = 0;
	logic        i_s_axi_arvalid = 0, i_s_axi_rready = 0;
	wire         o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
	wire  [1:0]  o_s_axi_bresp, o_s_axi_rresp;
	wire  [31:0] o_s_axi_rdata, o_bus_time, o_buf_time, o_tag_date, o_rdg_num;
	wire         o_tag_valid, o_tag_real, o_bus_ts_en, o_bus_rdg_en, o_buffer_clear, o_arm_event;
	wire  [16:0] o_rel_sec;
	wire  [19:0] o_rel_us;
	int          fail_count = 0, n_checks = 0, clr_n = 0, arm_n = 0;
	logic [31:0] rd, bt, ft, dt, rn;
	logic [19:0] us, u0;
	logic [1:0]  rs;
	logic        rr;
	logic [1:0]  te;
	logic [16:0] sc;
	rtsc_top #(.US_CYC(US_CYC), .SEC_CYC(SEC_CYC)) dut (.*);
	always #2.5 i_sys_clk = ~i_sys_clk;
	// Pulse counters; sampled before the edge lands
	always @(posedge i_sys_clk) begin
		clr_n += o_buffer_clear;
		arm_n += o_arm_event;
	end
	task chk(input logic [63:0] s, input logic [63:0] e);
		n_checks++;
		if (s !== e) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w, b;
		b = 0;
		i_s_axi_awaddr <= a;
		i_s_axi_wdata <= d;
		i_s_axi_wstrb <= 4'hf;
		i_s_axi_awvalid <= 1;
		i_s_axi_wvalid <= 1;
		i_s_axi_bready <= 1;
		while (!b) begin
			@(negedge i_sys_clk);
			aw = i_s_axi_awvalid && o_s_axi_awready;
			w = i_s_axi_wvalid && o_s_axi_wready;
			b = o_s_axi_bvalid;
			rs = o_s_axi_bresp;
			@(posedge i_sys_clk);
			if (aw) i_s_axi_awvalid <= 0;
			if (w) i_s_axi_wvalid <= 0;
		end
		i_s_axi_bready <= 0;
		@(posedge i_sys_clk);
		chk(rs, er);
	endtask
	task rdr(input logic [7:0] a, output logic [31:0] d);
		logic t, r;
		r = 0;
		i_s_axi_araddr <= a;
		i_s_axi_arvalid <= 1;
		i_s_axi_rready <= 1;
		while (!r) begin
			@(negedge i_sys_clk);
			t = i_s_axi_arvalid && o_s_axi_arready;
			r = o_s_axi_rvalid;
			d = o_s_axi_rdata;
			rs = o_s_axi_rresp;
			@(posedge i_sys_clk);
			if (t) i_s_axi_arvalid <= 0;
		end
		i_s_axi_rready <= 0;
		@(posedge i_sys_clk);
	endtask
	// Takes one reading and snapshots the one-cycle tag
	task strobe;
		int n;
		i_reading_strobe <= 1;
		@(posedge i_sys_clk);
		i_reading_strobe <= 0;
		n = 0;
		do begin
			@(negedge i_sys_clk);
			n++;
		end while (o_tag_valid !== 1'b1 && n < 4);
		chk(o_tag_valid, 1);
		bt = o_bus_time;
		ft = o_buf_time;
		dt = o_tag_date;
		rn = o_rdg_num;
		rr = o_tag_real;
		us = o_rel_us;
		sc = o_rel_sec;
		te = {o_bus_ts_en, o_bus_rdg_en};
		@(posedge i_sys_clk);
	endtask
	task t_reset;
		rdr(`RTSC_OFS_CTRL, rd);
		chk(rd, 0);
		rdr(`RTSC_OFS_RDG_NUM, rd);
		chk(rd, 0);
		rdr(`RTSC_OFS_REL_SEC, rd);
		chk(rd, 0);
		rdr(`RTSC_OFS_DATE, rd);
		chk(rd, 32'h06000101);
		rdr(8'h20, rd);
		chk({rs, rd}, {`RTSC_RESP_SLVERR, 32'h0});
		wr(8'h20, 32'h1, `RTSC_RESP_SLVERR);
		$display("reset test done");
	endtask
	task t_rel;
		wr(`RTSC_OFS_CMD, 32'h1, `RTSC_RESP_OKAY);
		strobe;
		chk(us < 20'h8, 1);
		chk(sc, 0);
		u0 = us;
		repeat (400) @(posedge i_sys_clk);
		strobe;
		chk((us - u0) inside {[100:103]}, 1);
		$display("relative test done");
	endtask
	task t_rdg;
		strobe;
		u0 = rn[19:0];
		strobe;
		chk(rn[19:0], u0 + 20'h1);
		wr(`RTSC_OFS_CMD, 32'h2, `RTSC_RESP_OKAY);
		rdr(`RTSC_OFS_RDG_NUM, rd);
		chk(rd, 0);
		strobe;
		rdr(`RTSC_OFS_RDG_NUM, rd);
		chk(rd, 1);
		$display("reading number test done");
	endtask
	task t_elem;
		for (int i = 0; i < 4; i++) begin
			wr(`RTSC_OFS_CTRL, i << 2, `RTSC_RESP_OKAY);
			// Element flags are latched per reading, so take one
			strobe;
			chk(te, {i[0], i[1]});
		end
		$display("element test done");
	endtask
	task t_rtc;
		int c0;
		wr(`RTSC_OFS_CTRL, 32'h0, `RTSC_RESP_OKAY);
		c0 = clr_n;
		wr(`RTSC_OFS_CTRL, 32'h1, `RTSC_RESP_OKAY);
		wr(`RTSC_OFS_TIME, 32'h000d2d1e, `RTSC_RESP_OKAY);
		chk(clr_n - c0, 1);
		rdr(`RTSC_OFS_TIME, rd);
		chk(rd & 32'hffffffc0, 32'h000d2d00);
		wr(`RTSC_OFS_CMD, 32'h1, `RTSC_RESP_OKAY);
		rdr(`RTSC_OFS_TIME, rd);
		chk(rd & 32'hffffffc0, 32'h000d2d00);
		strobe;
		chk({rr, bt & 32'hffffffc0}, {1'b1, 32'h000d2d00});
		chk(ft, bt);
		chk(dt, 32'h06000101);
		wr(`RTSC_OFS_CTRL, 32'h3, `RTSC_RESP_OKAY);
		strobe;
		chk(bt[24:16], 9'h00d);
		chk({rr, ft[24:16]}, {1'b1, 9'h101});
		chk(clr_n - c0, 1);
		wr(`RTSC_OFS_CMD, 32'h4, `RTSC_RESP_OKAY);
		rdr(`RTSC_OFS_TIME, rd);
		chk(rd[5:0], 0);
		wr(`RTSC_OFS_CTRL, 32'h2, `RTSC_RESP_OKAY);
		strobe;
		chk({rr, clr_n - c0}, {1'b0, 32'h2});
		$display("calendar test done");
	endtask
	task t_alarm;
		int n, a0;
		// Alarm hour in the 12-hour form currently selected
		wr(`RTSC_OFS_CTRL, 32'h3, `RTSC_RESP_OKAY);
		wr(`RTSC_OFS_TIME, 32'h01012d3b, `RTSC_RESP_OKAY);
		a0 = arm_n;
		wr(`RTSC_OFS_ALARM, 32'h81012e00, `RTSC_RESP_OKAY);
		rdr(`RTSC_OFS_ALARM, rd);
		chk(rd, 32'h81012e00);
		n = 0;
		while (arm_n == a0 && n < 1500) begin
			@(posedge i_sys_clk);
			n++;
		end
		chk(arm_n - a0, 1);
		$display("alarm test done");
	endtask
	initial begin
		repeat (10) @(posedge i_sys_clk);
		i_sys_rst <= 0;
		@(posedge i_sys_clk);
		t_reset;
		t_rel;
		t_rdg;
		t_elem;
		t_rtc;
		t_alarm;
		wrap_up;
	end
	// Whole run is near 1500 cycles
	initial begin
		#100000;
		fail_count++;
		wrap_up;
	end
endmodule
